// ===== bsm_defs.vh
`ifndef BSM_DEFS_VH
`define BSM_DEFS_VH
`define BSM_CPOL_BIT 0
`define BSM_CPHA_BIT 1
`define BSM_ORDER_BIT 2
`define BSM_CMD_ALL 4'hf
`define BSM_FILL_RESET 8'hff
`define BSM_SCK_HALF 4
`define BSM_CNT_W 16
`define BSM_PTR_W 16
`endif

// ===== bsm_buf2.v
`timescale 1ns/1ns
module bsm_buf2 #(
  parameter W = 8
) (
  input wire clock,
  input wire reset,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rp_r];
  always @(posedge clock) begin
    if (reset) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'd1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'd1;
      end
    end
  end
  always @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// ===== bsm_master.v
`timescale 1ns/1ns
`include "bsm_defs.vh"
// Overview of operation
// - start task begins a transfer shifting mosi out while capturing miso.
// - tx_buffer_done pulses once all tx_byte_count bytes are sent.
// - rx_buffer_done pulses once rx_byte_count bytes are captured.
// - transfer ends by itself when both counts are reached.
// - end event only after, or in the same cycle as, both buffer-done events.
// - stop task halts the engine, then stopped event pulses.
// - stop mid-byte finishes the current byte first.
// - stop while idle still pulses the stopped event.
// - stopping early still raises tx_buffer_done if not yet raised.
// - stopping early still raises rx_buffer_done if not yet raised.
// - suspend pauses after current byte; resume continues.
// - command_data_select low for command bytes, high for data bytes.
// - first command_byte_count bytes are commands, the rest data.
// - one chip select per slave, chosen by a slave index.
// - clock polarity and phase select modes 0 to 3.
// - pointers and counts are latched at start, so next values may load.
// - bytes received past rx_byte_count are discarded.
module bsm_master #(
  parameter CW = `BSM_CNT_W,
  parameter PW = `BSM_PTR_W,
  parameter NCS = 4,
  parameter HALF = `BSM_SCK_HALF
) (
  input wire clock,
  input wire reset,
  input wire task_start,
  input wire task_stop,
  input wire task_suspend,
  input wire task_resume,
  input wire cpol,
  input wire cpha,
  input wire lsb_first,
  input wire [7:0] fill_character,
  input wire [3:0] command_byte_count,
  input wire [1:0] slave_index,
  input wire [PW-1:0] tx_buffer_pointer,
  input wire [CW-1:0] tx_byte_count,
  input wire [PW-1:0] rx_buffer_pointer,
  input wire [CW-1:0] rx_byte_count,
  output reg tx_rd_req,
  output reg [PW-1:0] tx_rd_addr,
  input wire tx_rd_valid,
  input wire [7:0] tx_rd_data,
  output wire rx_wr_valid,
  output wire [PW+7:0] rx_wr_payload,
  input wire rx_wr_ready,
  output reg ev_started,
  output reg ev_tx_buffer_done,
  output reg ev_rx_buffer_done,
  output reg ev_end,
  output reg ev_stopped,
  output reg busy,
  output reg suspended,
  output reg [CW-1:0] tx_amount,
  output reg [CW-1:0] rx_amount,
  output reg sck,
  output reg mosi,
  input wire miso,
  output reg [NCS-1:0] cs_n,
  output reg command_data_select
);
  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_SHIFT = 3'd3;
  localparam S_PUSH = 3'd4;
  localparam S_SUSP = 3'd5;
  localparam S_DONE = 3'd6;

  reg [2:0] st_r;
  reg miso_m_r;
  reg miso_s_r;
  reg [PW-1:0] tptr_r;
  reg [PW-1:0] rptr_r;
  reg [CW-1:0] tmax_r;
  reg [CW-1:0] rmax_r;
  reg [CW-1:0] nbyte_r;
  reg [3:0] ncmd_r;
  reg [7:0] tsh_r;
  reg [7:0] rsh_r;
  reg [2:0] bit_r;
  reg [7:0] div_r;
  reg ph_r;
  reg stop_r;
  reg susp_r;
  reg txd_r;
  reg rxd_r;
  reg push_v_r;
  reg [PW+7:0] push_d_r;
  wire push_rdy;
  wire [CW-1:0] total = (tmax_r > rmax_r) ? tmax_r : rmax_r;
  wire tick = (div_r == HALF[7:0] - 8'd1);
  wire [7:0] tx_bits = lsb_first ? tsh_r : {tsh_r[0], tsh_r[1], tsh_r[2], tsh_r[3],
                                            tsh_r[4], tsh_r[5], tsh_r[6], tsh_r[7]};

  bsm_buf2 #(.W(PW+8)) u_rxbuf (
    .clock(clock),
    .reset(reset),
    .in_data(push_d_r),
    .in_valid(push_v_r),
    .in_ready(push_rdy),
    .out_data(rx_wr_payload),
    .out_valid(rx_wr_valid),
    .out_ready(rx_wr_ready)
  );

  always @(posedge clock) begin
    if (reset) begin
      miso_m_r <= 1'b0;
      miso_s_r <= 1'b0;
    end else begin
      miso_m_r <= miso;
      miso_s_r <= miso_m_r;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      st_r <= S_IDLE;
      tptr_r <= {PW{1'b0}};
      rptr_r <= {PW{1'b0}};
      tmax_r <= {CW{1'b0}};
      rmax_r <= {CW{1'b0}};
      nbyte_r <= {CW{1'b0}};
      ncmd_r <= 4'h0;
      tsh_r <= 8'h00;
      rsh_r <= 8'h00;
      bit_r <= 3'd0;
      div_r <= 8'h00;
      ph_r <= 1'b0;
      stop_r <= 1'b0;
      susp_r <= 1'b0;
      txd_r <= 1'b0;
      rxd_r <= 1'b0;
      push_v_r <= 1'b0;
      push_d_r <= {(PW+8){1'b0}};
      tx_rd_req <= 1'b0;
      tx_rd_addr <= {PW{1'b0}};
      ev_started <= 1'b0;
      ev_tx_buffer_done <= 1'b0;
      ev_rx_buffer_done <= 1'b0;
      ev_end <= 1'b0;
      ev_stopped <= 1'b0;
      busy <= 1'b0;
      suspended <= 1'b0;
      tx_amount <= {CW{1'b0}};
      rx_amount <= {CW{1'b0}};
      sck <= 1'b0;
      mosi <= 1'b0;
      cs_n <= {NCS{1'b1}};
      command_data_select <= 1'b1;
    end else begin
      ev_started <= 1'b0;
      ev_tx_buffer_done <= 1'b0;
      ev_rx_buffer_done <= 1'b0;
      ev_end <= 1'b0;
      ev_stopped <= 1'b0;
      tx_rd_req <= 1'b0;
      if (push_v_r && push_rdy) begin
        push_v_r <= 1'b0;
      end
      if (task_stop && st_r != S_IDLE) begin
        stop_r <= 1'b1;
      end
      if (task_suspend && st_r != S_IDLE) begin
        susp_r <= 1'b1;
      end
      if (st_r == S_IDLE) begin
        sck <= cpol;
      end
      case (st_r)
        S_IDLE: begin
          if (task_stop) begin
            ev_stopped <= 1'b1;
          end else if (task_start) begin
            tptr_r <= tx_buffer_pointer;
            rptr_r <= rx_buffer_pointer;
            tmax_r <= tx_byte_count;
            rmax_r <= rx_byte_count;
            ncmd_r <= command_byte_count;
            nbyte_r <= {CW{1'b0}};
            tx_amount <= {CW{1'b0}};
            rx_amount <= {CW{1'b0}};
            txd_r <= 1'b0;
            rxd_r <= 1'b0;
            stop_r <= 1'b0;
            susp_r <= 1'b0;
            busy <= 1'b1;
            ev_started <= 1'b1;
            cs_n <= ~({{(NCS-1){1'b0}}, 1'b1} << slave_index);
            st_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (stop_r || nbyte_r == total) begin
            st_r <= S_DONE;
          end else if (susp_r) begin
            suspended <= 1'b1;
            st_r <= S_SUSP;
          end else if (nbyte_r < tmax_r) begin
            tx_rd_req <= 1'b1;
            tx_rd_addr <= tptr_r + nbyte_r[PW-1:0];
            st_r <= S_WAIT;
          end else begin
            tsh_r <= fill_character;
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (tx_rd_valid || nbyte_r >= tmax_r) begin
            if (nbyte_r < tmax_r) begin
              tsh_r <= tx_rd_data;
            end
            command_data_select <= ({12'h000, ncmd_r} > nbyte_r) ? 1'b0 : 1'b1;
            bit_r <= 3'd0;
            div_r <= 8'h00;
            ph_r <= 1'b0;
            st_r <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (div_r == 8'h00 && !ph_r && !cpha) begin
            mosi <= tx_bits[bit_r];
          end
          div_r <= tick ? 8'h00 : div_r + 8'h01;
          if (tick) begin
            ph_r <= ~ph_r;
            sck <= ~sck;
            if (!ph_r) begin
              if (cpha) begin
                mosi <= tx_bits[bit_r];
              end else begin
                rsh_r <= lsb_first ? {miso_s_r, rsh_r[7:1]} : {rsh_r[6:0], miso_s_r};
              end
            end else begin
              if (cpha) begin
                rsh_r <= lsb_first ? {miso_s_r, rsh_r[7:1]} : {rsh_r[6:0], miso_s_r};
              end
              bit_r <= bit_r + 3'd1;
              if (bit_r == 3'd7) begin
                st_r <= S_PUSH;
              end
            end
          end
        end
        S_PUSH: begin
          if (!push_v_r || push_rdy) begin
            nbyte_r <= nbyte_r + {{(CW-1){1'b0}}, 1'b1};
            if (nbyte_r < tmax_r) begin
              tx_amount <= tx_amount + {{(CW-1){1'b0}}, 1'b1};
              if (nbyte_r + {{(CW-1){1'b0}}, 1'b1} == tmax_r) begin
                txd_r <= 1'b1;
                ev_tx_buffer_done <= 1'b1;
              end
            end
            if (nbyte_r < rmax_r) begin
              push_v_r <= 1'b1;
              push_d_r <= {rptr_r + nbyte_r[PW-1:0], rsh_r};
              rx_amount <= rx_amount + {{(CW-1){1'b0}}, 1'b1};
              if (nbyte_r + {{(CW-1){1'b0}}, 1'b1} == rmax_r) begin
                rxd_r <= 1'b1;
                ev_rx_buffer_done <= 1'b1;
              end
            end
            st_r <= S_FETCH;
          end
        end
        S_SUSP: begin
          if (stop_r) begin
            suspended <= 1'b0;
            st_r <= S_DONE;
          end else if (task_resume) begin
            susp_r <= 1'b0;
            suspended <= 1'b0;
            st_r <= S_FETCH;
          end
        end
        S_DONE: begin
          if (!push_v_r) begin
            if (!txd_r) begin
              ev_tx_buffer_done <= 1'b1;
            end
            if (!rxd_r) begin
              ev_rx_buffer_done <= 1'b1;
            end
            ev_end <= 1'b1;
            ev_stopped <= stop_r;
            stop_r <= 1'b0;
            susp_r <= 1'b0;
            busy <= 1'b0;
            cs_n <= {NCS{1'b1}};
            command_data_select <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== bsm_master_properties.sv
`timescale 1ns/1ns
module bsm_master_properties (
  input wire clock,
  input wire reset,
  input wire task_start,
  input wire task_stop,
  input wire cpol,
  input wire [1:0] slave_index,
  input wire ev_started,
  input wire ev_tx_buffer_done,
  input wire ev_rx_buffer_done,
  input wire ev_end,
  input wire ev_stopped,
  input wire busy,
  input wire suspended,
  input wire sck,
  input wire [3:0] cs_n,
  input wire rx_wr_valid,
  input wire rx_wr_ready,
  input wire [23:0] rx_wr_payload
);
  reg txd_r;
  reg rxd_r;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  always @(posedge clock) begin
    if (reset || ev_end) begin
      txd_r <= 1'b0;
      rxd_r <= 1'b0;
    end else begin
      txd_r <= txd_r | ev_tx_buffer_done;
      rxd_r <= rxd_r | ev_rx_buffer_done;
    end
  end
  sequence s_idle_start;
    task_start && !busy;
  endsequence
  sequence s_launch;
    ev_started && busy && !cs_n[slave_index];
  endsequence
  sequence s_rest;
    cs_n == 4'hf && !busy;
  endsequence
  AST_START: assert property (s_idle_start |=> s_launch)
    else $error("no launch after start");
  AST_BUSY_REFUSE: assert property (task_start && busy |=> !ev_started)
    else $error("start taken while busy");
  AST_END_BOTH: assert property (ev_end |->
    (txd_r || ev_tx_buffer_done) && (rxd_r || ev_rx_buffer_done))
    else $error("end without both done events");
  AST_STOP_IDLE: assert property (task_stop && !busy |=> ev_stopped)
    else $error("no stopped event when idle");
  AST_STOP_END: assert property (ev_stopped && $past(busy) |-> ev_end)
    else $error("stopped without end");
  AST_SCK_IDLE: assert property (s_rest ##1 (s_rest and $stable(cpol)) |-> sck == cpol)
    else $error("idle clock level wrong");
  AST_RX_HOLD: assert property (rx_wr_valid && !rx_wr_ready |=>
    rx_wr_valid && $stable(rx_wr_payload))
    else $error("stalled word dropped");
  AST_SUSP_QUIET: assert property (suspended [*2] |-> $stable(sck))
    else $error("clock moves while suspended");
endmodule
bind bsm_master bsm_master_properties chk_i (.*);

// ===== bsm_slave_model.sv
`timescale 1ns/1ns
module bsm_slave_model (
  input wire sck,
  input wire mosi,
  input wire cs_n,
  input wire cpol,
  input wire cpha,
  input wire lsb_first,
  input wire command_data_select,
  output wire miso,
  output reg [7:0] rx_byte,
  output reg rx_cds,
  output reg [15:0] n_bytes
);
  reg [2:0] bit_r;
  reg [7:0] sh_r;
  // sampling edge: rising sck in modes 0 and 3, falling in modes 1 and 2
  wire sclk = sck ^ cpol ^ cpha;
  wire [7:0] sh_nxt = lsb_first ? {mosi, sh_r[7:1]} : {sh_r[6:0], mosi};
  initial n_bytes = 16'h0;
  // echoes mosi; pulled up when not selected
  assign miso = cs_n ? 1'b1 : mosi;
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_r <= 3'h0;
    end else begin
      sh_r <= sh_nxt;
      bit_r <= bit_r + 3'h1;
      if (bit_r == 3'h0) begin
        rx_cds <= command_data_select;
      end
      if (bit_r == 3'h7) begin
        rx_byte <= sh_nxt;
        n_bytes <= n_bytes + 16'h1;
      end
    end
  end
endmodule

// ===== bsm_master_tb.sv
`timescale 1ns/1ns
module bsm_master_tb;
  reg clock, reset, task_start, task_stop, task_suspend, task_resume, cpol, cpha, lsb_first;
  reg tx_rd_valid, rx_wr_ready;
  reg [7:0] fill_character, tx_rd_data;
  reg [3:0] command_byte_count;
  reg [1:0] slave_index;
  reg [15:0] tx_buffer_pointer, tx_byte_count, rx_buffer_pointer, rx_byte_count;
  wire tx_rd_req, rx_wr_valid, ev_started, ev_tx_buffer_done, ev_rx_buffer_done, ev_end;
  wire ev_stopped, busy, suspended, sck, mosi, miso, command_data_select, rx_cds;
  wire [15:0] tx_rd_addr, tx_amount, rx_amount, n_bytes;
  wire [23:0] rx_wr_payload;
  wire [3:0] cs_n;
  wire [7:0] rx_byte;
  reg [7:0] n_txd, n_rxd, n_end, n_stop, n_push;
  reg [15:0] cur_tx, cur_cmd, nb0, nbd, seen, k;
  integer n_fail, num_checks, cyc, i;
  reg [31:0] rows [0:4];
  bsm_master bsm_master_i (.*);
  bsm_slave_model bsm_slave_model_i (.sck(sck), .mosi(mosi), .cs_n(cs_n[slave_index]),
    .cpol(cpol), .cpha(cpha), .lsb_first(lsb_first),
    .command_data_select(command_data_select), .miso(miso), .rx_byte(rx_byte),
    .rx_cds(rx_cds), .n_bytes(n_bytes));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function [7:0] exp_b(input [15:0] b);
    exp_b = (b < cur_tx) ? b[7:0] ^ 8'h5a : 8'hc3;
  endfunction
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task pulse_wait;
    begin
      while (n_bytes == nb0) @(posedge clock);
    end
  endtask
  task run(input [31:0] r);
    begin
      @(posedge clock);
      {cpol, cpha} <= r[11:10];
      lsb_first <= r[7];
      slave_index <= r[5:4];
      repeat (2) @(posedge clock);
      {n_txd, n_rxd, n_end, n_stop, n_push} = 40'h0;
      nb0 = n_bytes;
      cur_tx = r[31:24];
      cur_cmd = r[15:12];
      {tx_buffer_pointer, rx_buffer_pointer} <= 32'h1200_3400;
      {tx_byte_count, rx_byte_count} <= {8'h0, r[31:24], 8'h0, r[23:16]};
      command_byte_count <= r[15:12];
      task_start <= 1'b1;
      @(posedge clock);
      task_start <= 1'b0;
      while (!ev_started) @(posedge clock);
      {tx_buffer_pointer, rx_buffer_pointer} <= 32'h0055_0077;
      {tx_byte_count, rx_byte_count} <= 32'h0;
      cmp(cs_n ^ (4'h1 << slave_index), 4'hf);
      task_start <= 1'b1;
      @(posedge clock);
      task_start <= 1'b0;
      if (r[8]) begin
        pulse_wait;
        task_suspend <= 1'b1;
        @(posedge clock);
        task_suspend <= 1'b0;
        while (!suspended) @(posedge clock);
        nbd = n_bytes;
        repeat (150) @(posedge clock);
        cmp(n_bytes, nbd);
        task_resume <= 1'b1;
        @(posedge clock);
        task_resume <= 1'b0;
      end
      if (r[9]) begin
        pulse_wait;
        task_stop <= 1'b1;
        @(posedge clock);
        task_stop <= 1'b0;
        while (n_stop == 0) @(posedge clock);
      end
      while (n_end == 0) @(posedge clock);
      repeat (60) @(posedge clock);
      nbd = n_bytes - nb0;
      if (r[9]) begin
        cmp({tx_amount, rx_amount}, {nbd, nbd});
        cmp({n_txd, n_rxd, n_end, n_stop}, 32'h01010101);
        cmp(nbd < cur_tx, 1);
      end else begin
        cmp({tx_amount, rx_amount}, {cur_tx, 8'h0, r[23:16]});
        cmp({n_txd, n_rxd, n_end, n_stop}, 32'h01010100);
        cmp({n_push, nbd}, {r[23:16], 12'h0, r[3:0]});
      end
    end
  endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    tx_rd_valid <= tx_rd_req;
    tx_rd_data <= tx_rd_addr[7:0] ^ 8'h5a;
    rx_wr_ready <= cyc[4];
    n_txd = n_txd + ev_tx_buffer_done;
    n_rxd = n_rxd + ev_rx_buffer_done;
    n_end = n_end + ev_end;
    n_stop = n_stop + ev_stopped;
    if (rx_wr_valid && rx_wr_ready) begin
      cmp(rx_wr_payload, {16'h3400 + n_push, exp_b(n_push)});
      n_push = n_push + 1;
    end
    if (n_bytes != seen) begin
      seen = n_bytes;
      k = n_bytes - nb0 - 16'h1;
      cmp({rx_cds, rx_byte}, {k >= cur_cmd, exp_b(k)});
    end
    if (cyc == 10000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial begin
    {reset, task_start, task_stop, task_suspend, task_resume, cpol, cpha, lsb_first} = 8'h80;
    {tx_rd_valid, rx_wr_ready, tx_rd_data, slave_index, command_byte_count} = 16'h0;
    fill_character = 8'hc3;
    {tx_buffer_pointer, tx_byte_count, rx_buffer_pointer, rx_byte_count} = 64'h0;
    {n_fail, num_checks, cyc} = 96'h0;
    {seen, nb0, cur_tx, cur_cmd} = 64'h0;
    {rows[0], rows[1], rows[2]} = 96'h03031003_02040494_04022824;
    {rows[3], rows[4]} = 64'h05052db5_06061200;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    cmp({cs_n, sck, mosi, command_data_select, busy}, 8'hf2);
    for (i = 0; i < 5; i = i + 1) begin
      run(rows[i]);
    end
    {n_end, n_stop} = 16'h0;
    task_stop <= 1'b1;
    @(posedge clock);
    task_stop <= 1'b0;
    repeat (4) @(posedge clock);
    cmp({n_stop, n_end}, 16'h0100);
    give_verdict;
  end
endmodule
